// ==== design/ris_pkg.sv ====
// Constants and types for the redundant input selector.
// Assumes a single 125 MHz clock and a 32-bit Avalon-MM slave port.
package ris_pkg;

  // ----------------------------------------
  // Clock, link rates and switching time
  // ----------------------------------------
  localparam int CLK_HZ         = 125_000_000;
  localparam int BAUD_SLOW      = 9600;
  localparam int BAUD_FAST      = 38400;
  localparam int DIV_SLOW       = (CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW;
  localparam int DIV_FAST       = (CLK_HZ + BAUD_FAST / 2) / BAUD_FAST;
  localparam int SWITCH_TIME_MS = 100;
  localparam int SWITCH_CYCLES  = SWITCH_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0]  REG_CTRL  = 4'h0;
  localparam logic [3:0]  REG_ADDR  = 4'h4;
  localparam logic [3:0]  REG_STAT  = 4'h8;
  localparam int          CTRL_MD   = 0;
  localparam int          CTRL_FAST = 1;
  localparam int          ST_SEL    = 0;
  localparam int          ST_MODE   = 1;
  localparam int          ST_APRI   = 3;
  localparam int          ST_ABAK   = 4;
  localparam int          ST_RSEL   = 5;
  localparam int          ST_MIN    = 7;
  localparam logic [15:0] ADDR_RST  = 16'h3031;

  // ----------------------------------------
  // Frame characters
  // ----------------------------------------
  localparam logic [7:0] CH_OPEN  = 8'h7b;
  localparam logic [7:0] CH_CLOSE = 8'h7d;
  localparam logic [7:0] CH_C     = 8'h43;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_R     = 8'h52;
  localparam logic [7:0] CH_M     = 8'h4d;
  localparam logic [7:0] CH_P     = 8'h50;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_ZERO  = 8'h30;

  typedef enum logic [1:0] {RIS_AUTO, RIS_MANUAL, RIS_REMOTE} ris_mode_t;
  typedef enum logic [2:0] {PS_IDLE, PS_ADR0, PS_ADR1, PS_C1, PS_C2, PS_ARG,
                            PS_END} ris_pst_t;
  typedef enum logic [1:0] {CMD_CR, CMD_CM, CMD_SP, CMD_SA} ris_cmd_t;

endpackage

// ==== design/ris_uart.sv ====
// Byte-wide asynchronous receiver and transmitter, 8N1.
// Assumes rxd_in is already synchronised to clk_in.
`timescale 1ns/10ps
module ris_uart #(
  parameter logic [15:0] DIV_SLOW = 16'(ris_pkg::DIV_SLOW),
  parameter logic [15:0] DIV_FAST = 16'(ris_pkg::DIV_FAST)
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Rate select
  input  wire logic       fast_in,
  // Serial pins
  input  wire logic       rxd_in,
  output logic            txd_out,
  // Byte side
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out
);
  import ris_pkg::*;

  typedef struct packed {
    logic        rx_on;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_dat;
    logic        rx_vld;
    logic        tx_on;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    logic        txd;
  } ris_uart_st_t;

  ris_uart_st_t q;
  ris_uart_st_t d;
  logic [15:0]  div;

  // Rate is chosen at run time so either host figure can be matched
  assign div = fast_in ? DIV_FAST : DIV_SLOW; // [R11]

  always_comb
  begin
    d = q;
    d.rx_vld = 1'b0;
    // ----------------------------------------
    // Receiver: sample mid-bit, start/8 data/stop
    // ----------------------------------------
    if (!q.rx_on)
    begin
      if (!rxd_in)
      begin
        d.rx_on  = 1'b1;
        d.rx_cnt = {1'b0, div[15:1]};
        d.rx_bit = 4'h0;
      end
    end
    else if (q.rx_cnt != 16'h0)
      d.rx_cnt = q.rx_cnt - 16'h1;
    else
    begin
      d.rx_cnt = div - 16'h1;
      d.rx_bit = q.rx_bit + 4'h1;
      if (q.rx_bit == 4'h0)
        d.rx_on = !rxd_in;
      else if (q.rx_bit == 4'h9)
      begin
        // Bad stop bit drops the byte
        d.rx_on  = 1'b0;
        d.rx_vld = rxd_in; // [R10]
        d.rx_dat = q.rx_sh;
      end
      else
        d.rx_sh = {rxd_in, q.rx_sh[7:1]}; // [R10]
    end
    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    if (!q.tx_on)
    begin
      if (tx_valid_in)
      begin
        d.tx_on  = 1'b1;
        d.tx_sh  = {1'b1, tx_data_in, 1'b0}; // [R10]
        d.tx_cnt = div - 16'h1;
        d.tx_bit = 4'h0;
        d.txd    = 1'b0;
      end
    end
    else if (q.tx_cnt != 16'h0)
      d.tx_cnt = q.tx_cnt - 16'h1;
    else if (q.tx_bit == 4'h9)
    begin
      d.tx_on = 1'b0;
      d.txd   = 1'b1;
    end
    else
    begin
      d.tx_bit = q.tx_bit + 4'h1;
      d.txd    = q.tx_sh[q.tx_bit + 4'h1];
      d.tx_cnt = div - 16'h1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      q     <= '0;
      q.txd <= 1'b1;
    end
    else
      q <= d;
  end

  assign txd_out      = q.txd;
  assign tx_ready_out = !q.tx_on;
  assign rx_data_out  = q.rx_dat;
  assign rx_valid_out = q.rx_vld;

endmodule

// ==== design/ris_top.sv ====
// Redundant input selector: selection logic, indicators and serial
// command interpreter. Assumes alarm, button, supply and serial pins are
// asynchronous; register bus is Avalon-MM on ref_clk_in.
//
// Overview of operation
// [R01] Auto: primary alarmed, backup clean, go backup
// [R02] Auto on backup: return on clear or both
// [R03] Reset and power-up select primary first
// [R04] Alarm input high means level below threshold
// [R05] Buttons choose auto, manual, remote; manual picks
// [R06] Per-channel alarm, remote and supply lamps
// [R07] Alarm contact while either channel alarmed
// [R08] Link selects input, reports position and alarms
// [R09] Switch completes within the switching time
// [R10] Link framing 8N1
// [R11] Link rate selectable, slow or fast
// [R12] Point-to-point or multidrop bus, selectable
// [R13] Remote digit: 0 clear, 1 primary, 2 backup
// [R14] Min-auto digit 0/1, held until changed
// [R15] Address prefix only on multidrop bus
// [R16] Min-auto: hold unless selected alarmed alone
// [R17] Position reply: channel digit, mode digit
// [R18] Alarm reply: primary digit, backup digit
// [R19] Bad or foreign frames change nothing
// [R20] Remote selection overrides panel until cleared
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module ris_top #(
  parameter logic [15:0] DIV_SLOW      = 16'(ris_pkg::DIV_SLOW),
  parameter logic [15:0] DIV_FAST      = 16'(ris_pkg::DIV_FAST),
  parameter int          SWITCH_CYCLES = ris_pkg::SWITCH_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Channel alarms and supplies
  input  wire logic        alarm_primary_in,
  input  wire logic        alarm_backup_in,
  input  wire logic        psu1_ok_in,
  input  wire logic        psu2_ok_in,
  // Push buttons
  input  wire logic        btn_auto_in,
  input  wire logic        btn_manual_in,
  input  wire logic        btn_remote_in,
  input  wire logic        btn_pick_primary_in,
  input  wire logic        btn_pick_backup_in,
  // Serial link
  input  wire logic        uart_rxd_in,
  output logic             uart_txd_out,
  output logic             uart_txd_oe_out,
  // Relay, lamps and contact
  output logic             sel_backup_out,
  output logic             led_alarm_primary_out,
  output logic             led_alarm_backup_out,
  output logic             led_remote_out,
  output logic             led_psu1_out,
  output logic             led_psu2_out,
  output logic             alarm_contact_out
);
  import ris_pkg::*;

  typedef struct packed {
    logic        rx_s1;
    logic        rx_s2;
    logic [1:0]  a_s1;
    logic [1:0]  a_s2;
    logic [1:0]  a;
    logic [4:0]  b_s1;
    logic [4:0]  b_s2;
    logic [4:0]  b_prev;
    logic [1:0]  p_s1;
    logic [1:0]  p_s2;
    logic [1:0]  psu;
    ris_mode_t   mode;
    logic        man_sel;
    logic        sel;
    logic [1:0]  rsel;
    logic        minauto;
    logic        remote_led;
    logic        contact;
    logic        md;
    logic        fast;
    logic [15:0] uaddr;
    logic        wait_r;
    logic [31:0] rdata;
    ris_pst_t    ps;
    logic        cls;
    ris_cmd_t    cmd;
    logic [1:0]  arg;
    logic [63:0] tx_buf;
    logic [3:0]  tx_cnt;
    logic        tx_go;
    logic        oe;
    logic [23:0] pend;
  } ris_st_t;

  ris_st_t     q;
  ris_st_t     d;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        tx_ready;
  logic [4:0]  press;

  function automatic logic [1:0] mode_digit(input logic [1:0] rs, input ris_mode_t m);
    if (rs != 2'h0 || m == RIS_REMOTE)
      return 2'h1;
    return (m == RIS_MANUAL) ? 2'h2 : 2'h0; // [R17]
  endfunction

  ris_uart #(
    .DIV_SLOW (DIV_SLOW),
    .DIV_FAST (DIV_FAST)
  ) ris_uart_inst (
    .clk_in       (ref_clk_in),
    .rst_in       (sys_rst_in),
    .fast_in      (q.fast),
    .rxd_in       (q.rx_s2),
    .txd_out      (uart_txd_out),
    .tx_data_in   (q.tx_buf[63:56]),
    .tx_valid_in  (q.tx_go),
    .tx_ready_out (tx_ready),
    .rx_data_out  (rx_data),
    .rx_valid_out (rx_valid)
  );

  assign press = q.b_s2 & ~q.b_prev;

  always_comb
  begin
    d = q;
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    d.rx_s1  = uart_rxd_in;
    d.rx_s2  = q.rx_s1;
    d.a_s1   = {alarm_backup_in, alarm_primary_in};
    d.a_s2   = q.a_s1;
    d.a      = q.a_s2; // [R04]
    d.b_s1   = {btn_pick_backup_in, btn_pick_primary_in, btn_remote_in,
                btn_manual_in, btn_auto_in};
    d.b_s2   = q.b_s1;
    d.b_prev = q.b_s2;
    d.p_s1   = {psu2_ok_in, psu1_ok_in};
    d.p_s2   = q.p_s1;
    d.psu    = q.p_s2; // [R06]
    // ----------------------------------------
    // Panel mode and manual pick
    // ----------------------------------------
    if (press[0])
      d.mode = RIS_AUTO; // [R05]
    else if (press[1])
    begin
      d.mode    = RIS_MANUAL; // [R05]
      d.man_sel = q.sel;
    end
    else if (press[2])
      d.mode = RIS_REMOTE; // [R05]
    if (q.mode == RIS_MANUAL && press[3])
      d.man_sel = 1'b0; // [R05]
    if (q.mode == RIS_MANUAL && press[4])
      d.man_sel = 1'b1; // [R05]
    // ----------------------------------------
    // Selection
    // ----------------------------------------
    case (q.rsel)
      2'h1: d.sel = 1'b0; // [R20]
      2'h2: d.sel = 1'b1; // [R20]
      default:
        if (d.mode == RIS_MANUAL)
          d.sel = d.man_sel; // [R05]
        else if (!q.sel)
          d.sel = q.a[0] && !q.a[1]; // [R01] [R09]
        else if (q.minauto)
          d.sel = !(q.a[1] && !q.a[0]); // [R16]
        else
          d.sel = q.a[0] && !q.a[1]; // [R02]
    endcase
    // Same edge as the alarm lamps so contact and lamps never disagree
    d.contact = |d.a; // [R07]
    // Qualifying alarm waiting for the relay; only the checks read it
    d.pend = (q.a == 2'b01 && !q.sel && q.rsel == 2'h0 && q.mode != RIS_MANUAL)
             ? q.pend + 24'h1 : 24'h0;
    // ----------------------------------------
    // Avalon slave: one wait cycle, then answer
    // ----------------------------------------
    d.wait_r = 1'b1;
    if ((avs_read_in || avs_write_in) && q.wait_r)
    begin
      d.wait_r = 1'b0;
      d.rdata  = 32'h0;
      case (avs_address_in)
        REG_CTRL:
        begin
          d.rdata[CTRL_MD]   = q.md;
          d.rdata[CTRL_FAST] = q.fast;
        end
        REG_ADDR: d.rdata[15:0] = q.uaddr;
        REG_STAT:
        begin
          d.rdata[ST_SEL]          = q.sel;
          d.rdata[ST_MODE +: 2]    = mode_digit(q.rsel, q.mode);
          d.rdata[ST_APRI]         = q.a[0];
          d.rdata[ST_ABAK]         = q.a[1];
          d.rdata[ST_RSEL +: 2]    = q.rsel;
          d.rdata[ST_MIN]          = q.minauto;
        end
        default: d.rdata = 32'h0;
      endcase
    end
    if (avs_write_in && !q.wait_r)
    begin
      if (avs_address_in == REG_CTRL && avs_byteenable_in[0])
      begin
        d.md   = avs_writedata_in[CTRL_MD]; // [R12]
        d.fast = avs_writedata_in[CTRL_FAST]; // [R11]
      end
      if (avs_address_in == REG_ADDR && avs_byteenable_in[0])
        d.uaddr[7:0] = avs_writedata_in[7:0];
      if (avs_address_in == REG_ADDR && avs_byteenable_in[1])
        d.uaddr[15:8] = avs_writedata_in[15:8];
    end
    // ----------------------------------------
    // Command parser
    // ----------------------------------------
    if (rx_valid)
    begin
      if (rx_data == CH_OPEN)
        d.ps = q.md ? PS_ADR0 : PS_C1; // [R15]
      else
      begin
        d.ps = PS_IDLE; // [R19]
        case (q.ps)
          PS_ADR0: if (rx_data == q.uaddr[15:8]) d.ps = PS_ADR1; // [R15]
          PS_ADR1: if (rx_data == q.uaddr[7:0]) d.ps = PS_C1; // [R15]
          PS_C1:
          begin
            d.cls = (rx_data == CH_C);
            if (rx_data == CH_C || rx_data == CH_S)
              d.ps = PS_C2;
          end
          PS_C2:
            if (q.cls && rx_data == CH_R)
            begin
              d.cmd = CMD_CR;
              d.ps  = PS_ARG;
            end
            else if (q.cls && rx_data == CH_M)
            begin
              d.cmd = CMD_CM;
              d.ps  = PS_ARG;
            end
            else if (!q.cls && (rx_data == CH_P || rx_data == CH_A))
            begin
              d.cmd = (rx_data == CH_P) ? CMD_SP : CMD_SA; // [R08]
              d.ps  = PS_END;
            end
          PS_ARG:
            if (rx_data >= CH_ZERO &&
                rx_data <= CH_ZERO + ((q.cmd == CMD_CR) ? 8'h2 : 8'h1))
            begin
              d.arg = rx_data[1:0]; // [R13] [R14]
              d.ps  = PS_END;
            end
          PS_END:
            if (rx_data == CH_CLOSE)
              case (q.cmd)
                CMD_CR: d.rsel = q.arg; // [R13] [R20]
                CMD_CM: d.minauto = q.arg[0]; // [R14]
                default:
                  if (q.tx_cnt == 4'h0)
                  begin
                    // Reply held as one snapshot, sent first byte first
                    d.tx_buf = (q.cmd == CMD_SP)
                      ? {CH_S, CH_P, CH_ZERO + (q.sel ? 8'h2 : 8'h1), // [R17]
                         CH_ZERO + {6'h0, mode_digit(q.rsel, q.mode)}, CH_CLOSE, 24'h0}
                      : {CH_S, CH_A, CH_ZERO + {7'h0, q.a[0]}, // [R18]
                         CH_ZERO + {7'h0, q.a[1]}, CH_CLOSE, 24'h0};
                    d.tx_buf = q.md ? {CH_OPEN, q.uaddr, d.tx_buf[63:24]} // [R15]
                                    : {CH_OPEN, d.tx_buf[63:8]};
                    d.tx_cnt = q.md ? 4'h8 : 4'h6;
                  end
              endcase
          default: d.ps = PS_IDLE;
        endcase
      end
    end
    // ----------------------------------------
    // Reply sender and line driver enable
    // ----------------------------------------
    d.tx_go = 1'b0;
    if (q.tx_go)
    begin
      d.tx_buf = {q.tx_buf[55:0], 8'h0};
      d.tx_cnt = q.tx_cnt - 4'h1;
    end
    else if (q.tx_cnt != 4'h0 && tx_ready)
      d.tx_go = 1'b1;
    // Multidrop releases the bus between replies
    d.oe = !q.md || q.tx_cnt != 4'h0 || !tx_ready; // [R12]
    d.remote_led = (d.rsel != 2'h0) || (d.mode == RIS_REMOTE); // [R06]
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      q        <= '0; // [R03]
      q.rx_s1  <= 1'b1;
      q.rx_s2  <= 1'b1;
      q.wait_r <= 1'b1;
      q.uaddr  <= ADDR_RST;
      q.oe     <= 1'b1;
    end
    else
      q <= d;
  end

  assign avs_readdata_out      = q.rdata;
  assign avs_waitrequest_out   = q.wait_r;
  assign uart_txd_oe_out       = q.oe;
  assign sel_backup_out        = q.sel;
  assign led_alarm_primary_out = q.a[0];
  assign led_alarm_backup_out  = q.a[1];
  assign led_remote_out        = q.remote_led;
  assign led_psu1_out          = q.psu[0];
  assign led_psu2_out          = q.psu[1];
  assign alarm_contact_out     = q.contact;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_auto_to_backup : assert property ( // [R01]
    q.mode == RIS_AUTO && q.rsel == 2'h0 && !q.sel && q.a == 2'b01 && !press[1] |=> q.sel)
    else $error("Auto mode did not move to backup");
  a_auto_return : assert property ( // [R02]
    q.mode == RIS_AUTO && q.rsel == 2'h0 && !q.minauto && q.sel && !press[1] &&
    (!q.a[0] || q.a[1]) |=> !q.sel)
    else $error("Auto mode did not return to primary");
  a_reset_primary : assert property ( // [R03]
    $past(sys_rst_in) |-> !sel_backup_out)
    else $error("Primary not selected after reset");
  a_contact_level : assert property ( // [R07]
    alarm_contact_out == (led_alarm_primary_out || led_alarm_backup_out))
    else $error("Alarm contact disagrees with channel alarms");
  a_switch_time : assert property ( // [R09]
    q.pend < 24'(SWITCH_CYCLES))
    else $error("Switch took longer than allowed");
  a_remote_force : assert property ( // [R20]
    q.rsel != 2'h0 ##1 q.rsel == $past(q.rsel) |-> sel_backup_out == q.rsel[1])
    else $error("Remote selection not obeyed");
  a_min_hold : assert property ( // [R16]
    q.mode == RIS_AUTO && q.rsel == 2'h0 && q.minauto && q.sel &&
    !(q.a[1] && !q.a[0]) |=> q.sel)
    else $error("Minimum auto switching left backup");
  a_bad_frame : assert property ( // [R19]
    rx_valid && q.ps == PS_END && rx_data != CH_CLOSE
    |=> $stable(q.rsel) && $stable(q.minauto) && q.tx_cnt <= $past(q.tx_cnt))
    else $error("Bad frame changed state");
  a_p2p_drive : assert property ( // [R12]
    !q.md [*2] |-> uart_txd_oe_out)
    else $error("Point-to-point driver not enabled");

endmodule

// ==== tb/ris_host_model.sv ====
// Remote host model: sends and receives 8N1 characters on the link.
// Assumes the bench calls its tasks and resolves the device's line.
`timescale 1ns/10ps
module ris_host_model #(
  parameter int DIV_S = 16,
  parameter int DIV_F = 8
) (
  // Clock and rate
  input  wire logic clk_in,
  input  wire logic fast_in,
  // Serial lines
  input  wire logic line_in,
  output logic      txd_out
);
  // ----------------------------------------
  // Bit timing and framing
  // ----------------------------------------
  initial txd_out = 1'b1;

  task automatic bit_wait();
    repeat (fast_in ? DIV_F : DIV_S) @(posedge clk_in);
  endtask

  task automatic send(input logic [7:0] b);
    @(posedge clk_in);
    txd_out <= 1'b0;
    bit_wait();
    for (int i = 0; i < 8; i++)
    begin
      txd_out <= b[i];
      bit_wait();
    end
    txd_out <= 1'b1;
    bit_wait();
  endtask

  // Bounded wait; ok stays low when no character arrives
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    ok = 1'b0;
    while (line_in !== 1'b1 && n < 3000)
    begin
      @(posedge clk_in);
      n++;
    end
    while (line_in !== 1'b0 && n < 3000)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n < 3000)
    begin
      repeat ((fast_in ? DIV_F : DIV_S) / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
        bit_wait();
        b[i] = line_in;
      end
      bit_wait();
      ok = (line_in === 1'b1);
    end
  endtask
endmodule

// ==== tb/ris_top_tb_top.sv ====
// Bench for the redundant input selector: bus, pin and link sequences.
// Assumes a biased multidrop line that idles at mark when released.
`timescale 1ns/10ps
module ris_top_tb_top;
  import ris_pkg::*;
  localparam int SW = 20;
  localparam logic [5:0] AP = 6'b011001;
  localparam logic [5:0] AB = 6'b010100;
  localparam logic [5:0] SL = 6'b001001;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic        ap = 1'b0;
  logic        ab = 1'b0;
  logic [4:0]  btn = 5'h00;
  logic        fast = 1'b0;
  logic        rxd, txd, oe, line, sel, la, lb, lr, lp1, lp2, con;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #4 clk = ~clk;
  // Bias holds mark while the device releases the bus
  assign line = oe ? txd : 1'b1;

  ris_top #(.DIV_SLOW(16'h0010), .DIV_FAST(16'h0008), .SWITCH_CYCLES(SW)) ris_top_inst (
    .ref_clk_in(clk), .sys_rst_in(rst), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .alarm_primary_in(ap), .alarm_backup_in(ab), .psu1_ok_in(1'b1), .psu2_ok_in(1'b0),
    .btn_auto_in(btn[0]), .btn_manual_in(btn[1]), .btn_remote_in(btn[2]),
    .btn_pick_primary_in(btn[3]), .btn_pick_backup_in(btn[4]),
    .uart_rxd_in(rxd), .uart_txd_out(txd), .uart_txd_oe_out(oe),
    .sel_backup_out(sel), .led_alarm_primary_out(la), .led_alarm_backup_out(lb),
    .led_remote_out(lr), .led_psu1_out(lp1), .led_psu2_out(lp2),
    .alarm_contact_out(con));

  ris_host_model ris_host_model_inst (
    .clk_in(clk), .fast_in(fast), .line_in(line), .txd_out(rxd));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("samples_checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50)
    begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  task automatic set(input logic a, input logic b);
    @(posedge clk);
    ap <= a;
    ab <= b;
    repeat (SW) @(posedge clk);
  endtask

  task automatic press(input int k);
    @(posedge clk);
    btn <= 5'h01 << k;
    repeat (8) @(posedge clk);
    btn <= 5'h00;
    repeat (8) @(posedge clk);
  endtask

  // Empty reply string means no answer is expected
  task automatic talk(input string tx, input string rx);
    logic [7:0] b;
    logic       ok;
    fork
      for (int i = 0; i < tx.len(); i++)
        ris_host_model_inst.send(tx[i]);
      begin
        if (rx.len() == 0)
        begin
          ris_host_model_inst.recv(b, ok);
          check(32'(ok), 32'h0);
        end
        for (int i = 0; i < rx.len(); i++)
        begin
          ris_host_model_inst.recv(b, ok);
          check(32'({ok, b}), 32'({1'b1, rx[i]}));
        end
      end
    join
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] q;
    repeat (2) @(posedge clk);
    check(32'({sel, wreq}), 32'h1);
    rst <= 1'b0;
    rchk(REG_CTRL, 32'h0);
    rchk(REG_ADDR, 32'h3031);
    rchk(4'hc, 32'h0);
    bus(1'b1, REG_STAT, 32'hff, q);
    rchk(REG_STAT, 32'h0);
    check(32'({lp1, lp2}), 32'h2);
    for (int i = 0; i < 6; i++)
    begin
      set(AP[i], AB[i]);
      check(32'(sel), 32'(SL[i]));
      check(32'({la, lb, con}), 32'({AP[i], AB[i], AP[i] | AB[i]}));
    end
    talk("{SP}", "{SP10}");
    set(1'b0, 1'b1);
    talk("{SA}", "{SA01}");
    talk("{CR2}", "");
    check(32'({sel, lr}), 32'h3);
    talk("{SP}", "{SP21}");
    rchk(REG_STAT, 32'h53);
    talk("{CR3}", "");
    talk("{CX1}", "");
    talk("CR0}", "");
    talk("{CR1X}", "");
    rchk(REG_STAT, 32'h53);
    set(1'b1, 1'b0);
    talk("{CR1}", "");
    check(32'(sel), 32'h0);
    talk("{CR0}", "");
    check(32'(sel), 32'h1);
    set(1'b0, 1'b1);
    bus(1'b1, REG_CTRL, 32'h3, q);
    fast <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(oe), 32'h0);
    talk("{01SA}", "{01SA01}");
    talk("{02SA}", "");
    talk("{SA}", "");
    rchk(REG_CTRL, 32'h3);
    bus(1'b1, REG_CTRL, 32'h0, q);
    fast <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(oe), 32'h1);
    talk("{CM1}", "");
    rchk(REG_STAT, 32'h90);
    set(1'b1, 1'b0);
    set(1'b0, 1'b0);
    check(32'(sel), 32'h1);
    set(1'b0, 1'b1);
    check(32'(sel), 32'h0);
    talk("{CM0}", "");
    set(1'b0, 1'b0);
    press(1);
    press(4);
    check(32'(sel), 32'h1);
    talk("{SP}", "{SP22}");
    press(3);
    check(32'(sel), 32'h0);
    press(2);
    check(32'(lr), 32'h1);
    talk("{SP}", "{SP11}");
    press(0);
    set(1'b1, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(sel), 32'h0);
    rst <= 1'b0;
    repeat (SW) @(posedge clk);
    check(32'(sel), 32'h1);
    end_sim();
  end
endmodule
